// ===== design/cat_top.sv
// compare unit with auto-conversion trigger, APB registers and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "cat_cfg.svh"
module cat_top (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire cat_pkg::cat_addr_t paddr,
  input  wire cat_pkg::cat_word_t pwdata,
  output logic                  pready,
  output logic                  pslverr,
  output cat_pkg::cat_word_t    prdata,
  input  wire logic             adcEnable,
  input  wire logic             sleepReq,
  output logic                  adcStart,
  output logic                  compareOutPin,
  output logic                  compareOutPinOeN,
  output logic                  irq
);
  import cat_pkg::*;

  cat_mode_t  compareModeField;
  cat_count_t compareValue;
  cat_count_t timerCount;
  logic [1:0] status;
  logic [1:0] mask;
  logic       timerOn;
  logic       adcEnMeta;
  logic       adcEnSync;
  logic       sleepMeta;
  logic       sleepSync;
  logic       matchNow;
  logic       matchPrev;
  logic       matchEv;
  logic       trigArm;
  logic       tick;
  logic       overflow;
  logic       compareLatch;
  logic       badAddr;
  logic       wrEn;
  logic       wrCtrl;
  logic       wrTmrL;
  logic       wrTmrH;
  logic [1:0] next_status;
  logic [1:0] statSet;
  logic [1:0] statClr;
  cat_word_t  next_prdata;
  logic       next_bad;
  logic       compareDrives;
  logic [1:0] next_mask;

  // pins from outside pass two flops first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      adcEnMeta <= 1'b0;
      adcEnSync <= 1'b0;
      sleepMeta <= 1'b0;
      sleepSync <= 1'b0;
    end else begin
      adcEnMeta <= adcEnable;
      adcEnSync <= adcEnMeta;
      sleepMeta <= sleepReq;
      sleepSync <= sleepMeta;
    end
  end

  // APB: zero wait states, read data captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && badAddr;
  assign wrEn    = psel && penable && pwrite && !badAddr;
  assign wrCtrl  = wrEn && (paddr == `CAT_OFF_CTRL);
  assign wrTmrL  = wrEn && (paddr == `CAT_OFF_TMRL);
  assign wrTmrH  = wrEn && (paddr == `CAT_OFF_TMRH);

  always_comb begin
    next_prdata = 32'h00000000;
    next_bad    = 1'b0;
    case (paddr)
      `CAT_OFF_CTRL: next_prdata = {28'h0000000, compareModeField};
      `CAT_OFF_TMRL: next_prdata = {24'h000000, timerCount[7:0]};
      `CAT_OFF_TMRH: next_prdata = {24'h000000, timerCount[15:8]};
      `CAT_OFF_CMPL: next_prdata = {24'h000000, compareValue[7:0]};
      `CAT_OFF_CMPH: next_prdata = {24'h000000, compareValue[15:8]};
      `CAT_OFF_STAT: next_prdata = {30'h00000000, status};
      `CAT_OFF_MASK: next_prdata = {30'h00000000, mask};
      `CAT_OFF_TCTL: next_prdata = {31'h00000000, timerOn};
      default:       next_bad    = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      badAddr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h00000000 : next_prdata;
      badAddr <= next_bad;
    end
  end

  // control, compare pair and timer control
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      compareModeField <= `CAT_CTRL_RST;
    end else if (wrCtrl) begin
      compareModeField <= pwdata[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      compareValue <= 16'h0000;
    end else if (wrEn) begin
      if (paddr == `CAT_OFF_CMPL) begin
        compareValue[7:0] <= pwdata[7:0];
      end
      if (paddr == `CAT_OFF_CMPH) begin
        compareValue[15:8] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timerOn <= 1'b0;
      mask    <= 2'h0;
    end else if (wrEn) begin
      if (paddr == `CAT_OFF_TCTL) begin
        timerOn <= pwdata[`CAT_TCTL_ON];
      end
      if (paddr == `CAT_OFF_MASK) begin
        mask <= pwdata[1:0];
      end
    end
  end

  cat_timer u_timer (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .timerOn      (timerOn),
    .compareValue (compareValue),
    .trigArm      (trigArm),
    .wrLow        (wrTmrL),
    .wrHigh       (wrTmrH),
    .wrByte       (pwdata[7:0]),
    .tick         (tick),
    .overflow     (overflow),
    .timerCount   (timerCount)
  );

  // match detection; a stopped system clock in sleep cannot compare
  assign matchNow = (timerCount == compareValue) && !sleepSync;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      matchPrev <= 1'b0;
    end else begin
      matchPrev <= matchNow;
    end
  end
  // one event per match, not one per cycle the count sits there
  assign matchEv  = matchNow && !matchPrev;
  assign trigArm  = matchEv && (compareModeField == `CAT_MODE_TRIG);
  // combinational so the converter sees the match cycle itself
  assign adcStart = trigArm && adcEnSync;

  // sticky status, set wins over a write-one clear
  always_comb begin
    statSet = 2'h0;
    statSet[`CAT_STAT_OVF] = overflow;
    statSet[`CAT_STAT_CMP] = matchEv && compareModeField[3];
    statClr = (wrEn && (paddr == `CAT_OFF_STAT)) ? pwdata[1:0] : 2'h0;
    next_status = (status & ~statClr) | statSet;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status <= 2'h0;
    end else begin
      status <= next_status;
    end
  end

  // the mask written in this cycle counts too, so irq never lags a mask change
  assign next_mask = (wrEn && (paddr == `CAT_OFF_MASK)) ? pwdata[1:0] : mask;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & next_mask);
    end
  end

  // output latch: only the set/clear modes take the pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      compareLatch <= 1'b0;
    end else if (wrCtrl && (pwdata[3:0] == `CAT_CTRL_RST)) begin
      compareLatch <= 1'b0;
    end else if (matchEv && (compareModeField == `CAT_MODE_SET)) begin
      compareLatch <= 1'b1;
    end else if (matchEv && (compareModeField == `CAT_MODE_CLR)) begin
      compareLatch <= 1'b0;
    end
  end

  assign compareDrives    = (compareModeField == `CAT_MODE_SET)
                            || (compareModeField == `CAT_MODE_CLR);
  // software interrupt and trigger modes leave the pin alone
  assign compareOutPinOeN = !compareDrives;
  assign compareOutPin    = compareLatch;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  trig_same_cycle_a: assert property (
    (compareModeField == `CAT_MODE_TRIG) && adcEnSync
    && (timerCount == compareValue) && !matchPrev && !sleepSync
    |-> adcStart)
    else $error("trigger not raised in the match cycle");
  trig_sets_flag_a: assert property (
    adcStart |=> status[`CAT_STAT_CMP])
    else $error("trigger mode lost the compare flag");
  zero_ctrl_low_a: assert property (
    wrCtrl && (pwdata[3:0] == 4'h0) |=> !compareOutPin)
    else $error("latch not cleared by zero control");
  swi_no_pin_a: assert property (
    (compareModeField == `CAT_MODE_SWI) |-> compareOutPinOeN)
    else $error("pin driven in software interrupt mode");
  swi_no_trigger_a: assert property (
    (compareModeField == `CAT_MODE_SWI) |-> !adcStart)
    else $error("software interrupt mode started a conversion");
  trig_no_pin_a: assert property (
    (compareModeField == `CAT_MODE_TRIG) |-> compareOutPinOeN && !compareDrives)
    else $error("pin driven in trigger mode");
  trig_needs_adc_a: assert property (
    !adcEnSync |-> !adcStart)
    else $error("conversion started with converter off");
  sleep_no_match_a: assert property (
    sleepSync |=> !$rose(status[`CAT_STAT_CMP]))
    else $error("match seen during sleep");
  match_event_a: assert property (
    matchEv && compareModeField[3]
    |=> status[`CAT_STAT_CMP]
    ##1 (status[`CAT_STAT_CMP] || $past(statClr[`CAT_STAT_CMP])))
    else $error("match did not set a sticky flag");
  period_restart_a: assert property (
    trigArm && !wrTmrL && !wrTmrH ##1 (!wrTmrL && !wrTmrH) [*4]
    |-> timerCount == 16'h0000 || !timerOn || compareValue != $past(compareValue, 4))
    else $error("compare pair did not act as period");
  irq_level_a: assert property (
    |(status & mask) |-> irq)
    else $error("interrupt low while unmasked flag set");
  irq_low_a: assert property (
    !(|(status & mask)) |-> !irq)
    else $error("interrupt high with no unmasked flag");
  cmp_low_byte_a: assert property (
    wrEn && (paddr == `CAT_OFF_CMPL) |=> compareValue[7:0] == $past(pwdata[7:0]))
    else $error("compare low byte write lost");
  cmp_high_byte_a: assert property (
    wrEn && (paddr == `CAT_OFF_CMPH)
    |=> compareValue == {$past(pwdata[7:0]), $past(compareValue[7:0])})
    else $error("compare high byte write disturbed the pair");
  ovf_sets_flag_a: assert property (
    overflow |=> status[`CAT_STAT_OVF])
    else $error("rollover did not set the overflow flag");
  ovf_only_max_a: assert property (
    timerCount != `CAT_COUNT_MAX |=> !$rose(status[`CAT_STAT_OVF]))
    else $error("overflow flag set without a rollover");
  unmapped_zero_a: assert property (
    psel && penable && !pwrite && badAddr |-> prdata == 32'h00000000)
    else $error("unmapped read returned data");
  ctrl_write_a: assert property (
    wrCtrl |=> compareModeField == $past(pwdata[3:0]))
    else $error("mode field write lost");
  set_on_match_a: assert property (
    matchEv && (compareModeField == `CAT_MODE_SET) && !wrCtrl |=> compareOutPin)
    else $error("set mode match left the latch low");
  clr_on_match_a: assert property (
    matchEv && (compareModeField == `CAT_MODE_CLR) && !wrCtrl |=> !compareOutPin)
    else $error("clear mode match left the latch high");
  flag_clear_a: assert property (
    wrEn && (paddr == `CAT_OFF_STAT) && pwdata[`CAT_STAT_CMP]
    && !statSet[`CAT_STAT_CMP] |=> !status[`CAT_STAT_CMP])
    else $error("compare flag not cleared by a written one");
  start_only_trig_a: assert property (
    !trigArm |-> !adcStart)
    else $error("conversion started outside a trigger match");
  start_pulse_a: assert property (
    adcStart |=> !adcStart)
    else $error("trigger pulse longer than one cycle");

  trig_fire_c: cover property (adcStart ##[1:8] timerCount == 16'h0000);
  overflow_c: cover property (status[`CAT_STAT_OVF] && irq);
  set_pin_c: cover property (!compareOutPinOeN && compareOutPin);
  write_race_c: cover property (trigArm ##[1:4] (wrTmrL && tick));
  clr_pin_c: cover property (!compareOutPinOeN && $fell(compareOutPin));
endmodule // cat_top
`default_nettype wire

// ===== design/cat_cfg.svh
// constants of the compare and auto-conversion trigger block
// Behaviour
// - a trigger reset clears the 16-bit timer count to zero.
// - the trigger reset never sets the timer overflow flag.
// - trigger mode still raises the compare interrupt flag on a match.
// - in trigger mode the compare pair is the timer period.
// - a timer byte write beats a coinciding trigger reset.
// - writing zero to compare control forces the output latch low.
// - mode 1010 leaves the pin undriven and only flags the match.
// - mode 1011 resets the timer, starts a conversion, pin undriven.
// - the trigger output asserts in the match cycle itself.
// - the count clears only on the next timer tick after the match.
// - if the match is gone by that tick, the reset is skipped.
// - matching stops while the device sleeps.
// - the count rolls from FFFF to zero and sets the overflow flag.
// - compare equal to count raises a match event.
`ifndef CAT_CFG_SVH
`define CAT_CFG_SVH
`define CAT_OFF_CTRL   8'h00
`define CAT_OFF_TMRL   8'h04
`define CAT_OFF_TMRH   8'h08
`define CAT_OFF_CMPL   8'h0C
`define CAT_OFF_CMPH   8'h10
`define CAT_OFF_STAT   8'h14
`define CAT_OFF_MASK   8'h18
`define CAT_OFF_TCTL   8'h1C
`define CAT_MODE_SET   4'h8
`define CAT_MODE_CLR   4'h9
`define CAT_MODE_SWI   4'hA
`define CAT_MODE_TRIG  4'hB
`define CAT_CTRL_RST   4'h0
`define CAT_STAT_OVF   0
`define CAT_STAT_CMP   1
`define CAT_TCTL_ON    0
`define CAT_TICK_LAST  2'h3
`define CAT_COUNT_MAX  16'hFFFF
`endif

// ===== design/cat_pkg.sv
// types shared by the compare and trigger block
package cat_pkg;
  typedef logic [7:0]  cat_addr_t;
  typedef logic [31:0] cat_word_t;
  typedef logic [15:0] cat_count_t;
  typedef logic [7:0]  cat_byte_t;
  typedef logic [3:0]  cat_mode_t;
  typedef enum {CAT_IDLE, CAT_ARMED} cat_rst_state_t;
endpackage

// ===== design/cat_timer.sv
// 16-bit timer with instruction-rate tick and deferred trigger reset
`timescale 1ns/1ps
`default_nettype none
`include "cat_cfg.svh"
module cat_timer (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              timerOn,
  input  wire cat_pkg::cat_count_t compareValue,
  input  wire logic              trigArm,
  input  wire logic              wrLow,
  input  wire logic              wrHigh,
  input  wire cat_pkg::cat_byte_t wrByte,
  output logic                   tick,
  output logic                   overflow,
  output cat_pkg::cat_count_t    timerCount
);
  import cat_pkg::*;
  logic [1:0]     divCnt;
  cat_rst_state_t state;
  logic           wrAny;
  logic           doReset;
  logic           stillMatch;

  // tick at a quarter of ref_clk, like an instruction clock
  always_ff @(posedge ref_clk) begin
    if (rst || !timerOn) begin
      divCnt <= 2'h0;
    end else begin
      divCnt <= divCnt + 2'h1;
    end
  end
  assign tick       = timerOn && (divCnt == `CAT_TICK_LAST);
  assign wrAny      = wrLow || wrHigh;
  assign stillMatch = (timerCount == compareValue);
  assign doReset    = (state == CAT_ARMED) && tick && stillMatch;
  assign overflow   = tick && !wrAny && !doReset
                      && (timerCount == `CAT_COUNT_MAX);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= CAT_IDLE;
    end else begin
      case (state)
        CAT_IDLE: begin
          if (trigArm) begin
            state <= CAT_ARMED;
          end
        end
        CAT_ARMED: begin
          // a write consumes the pending reset
          if ((tick || wrAny) && !trigArm) begin
            state <= CAT_IDLE;
          end
        end
        default: state <= CAT_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timerCount <= 16'h0000;
    end else if (wrAny) begin
      // the written byte wins over reset and increment
      if (wrLow) begin
        timerCount[7:0] <= wrByte;
      end
      if (wrHigh) begin
        timerCount[15:8] <= wrByte;
      end
    end else if (doReset) begin
      timerCount <= 16'h0000;
    end else if (tick) begin
      timerCount <= timerCount + 16'h0001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  trig_clears_count_a: assert property (
    (state == CAT_ARMED) && tick && stillMatch && !wrAny |=> timerCount == 16'h0000)
    else $error("trigger reset did not clear the count");
  no_ovf_on_reset_a: assert property (
    doReset |-> !overflow)
    else $error("trigger reset raised overflow");
  write_beats_reset_a: assert property (
    wrLow && !wrHigh |=> timerCount[7:0] == $past(wrByte))
    else $error("low byte write lost");
  hold_until_tick_a: assert property (
    (state == CAT_ARMED) && !tick && !wrAny |=> timerCount == $past(timerCount))
    else $error("count moved before the timer tick");
  skip_lost_match_a: assert property (
    (state == CAT_ARMED) && tick && !stillMatch && !wrAny
    |=> timerCount == $past(timerCount) + 16'h0001)
    else $error("reset taken although match was removed");
  rollover_flag_a: assert property (
    overflow |=> timerCount == 16'h0000)
    else $error("overflow without rollover to zero");
endmodule // cat_timer
`default_nettype wire

// ===== tb/cat_adc_model.sv
// converter start-input model: enable level and conversion counter
`timescale 1ns/1ps
`default_nettype none
module cat_adc_model (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic enReq,
  input  wire logic adcStart,
  output logic      adcEnable,
  output int        convCount
);
  // enable moves only after an edge, as a converter control bit would
  always_ff @(posedge ref_clk) begin
    adcEnable <= rst ? 1'b0 : enReq;
  end
  // a start pulse is only taken while the converter is enabled
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      convCount <= 0;
    end else if (adcStart && adcEnable) begin
      convCount <= convCount + 1;
    end
  end
endmodule // cat_adc_model
`default_nettype wire

// ===== tb/compare_autoconv_trigger_tb.sv
// self-checking bench for the compare unit with auto-conversion trigger
`timescale 1ns/1ps
`default_nettype none
`include "cat_cfg.svh"
module compare_autoconv_trigger_tb;
  import cat_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  cat_addr_t   paddr = 8'h00;
  cat_word_t   pwdata = 32'h0;
  logic        sleepReq = 1'b0;
  logic        enReq = 1'b1;
  logic        pready, pslverr, irq, adcEnable, adcStart, compareOutPin, compareOutPinOeN;
  cat_word_t   prdata, rd;
  logic        err;
  logic [15:0] lfsr = 16'h66A5; // seed 26277
  int          convCount, cyc, n, v, base;
  int          startCount = 0;
  int          fail_count = 0;
  int          n_tests = 0;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (adcStart === 1'b1) startCount <= startCount + 1;

  cat_top dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .adcEnable(adcEnable), .sleepReq(sleepReq),
    .adcStart(adcStart), .compareOutPin(compareOutPin),
    .compareOutPinOeN(compareOutPinOeN), .irq(irq));
  cat_adc_model adc (.ref_clk(ref_clk), .rst(rst), .enReq(enReq), .adcStart(adcStart),
    .adcEnable(adcEnable), .convCount(convCount));

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // one APB transfer; answer taken at the edge where pready is seen high
  task automatic apb(input logic wr, input cat_addr_t a, input cat_word_t d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // which 0 waits for a trigger pulse, 1 for the interrupt
  task automatic wait_for(input int which, output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
    end while ((which ? irq : adcStart) !== 1'b1 && c < 3000);
    if (c >= 3000) begin
      fail_count++;
      finish_test();
    end
  endtask

  // timer stopped while both pairs are loaded, so no stray match is seen
  task automatic prog(input cat_mode_t m, input logic [15:0] t, input logic [15:0] c);
    apb(1'b1, `CAT_OFF_TCTL, 32'h0);
    apb(1'b1, `CAT_OFF_TMRL, {24'h0, t[7:0]});
    apb(1'b1, `CAT_OFF_TMRH, {24'h0, t[15:8]});
    apb(1'b1, `CAT_OFF_CMPL, {24'h0, c[7:0]});
    apb(1'b1, `CAT_OFF_CMPH, {24'h0, c[15:8]});
    apb(1'b1, `CAT_OFF_CTRL, {28'h0, m});
    apb(1'b1, `CAT_OFF_STAT, 32'h3);
    apb(1'b1, `CAT_OFF_TCTL, 32'h1);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, cat_addr_t'(i * 4), 32'h0);
      chk("reset register", 32'h0, rd);
    end
    apb(1'b1, 8'h20, 32'hFF);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, 32'(err));
    chk("reset pin enable", 32'h1, 32'(compareOutPinOeN));
    // rollover flag, interrupt raise and clear
    apb(1'b1, `CAT_OFF_MASK, 32'h1);
    prog(`CAT_MODE_SWI, 16'hFFFE, 16'h1234);
    wait_for(1, cyc);
    apb(1'b0, `CAT_OFF_STAT, 32'h0);
    chk("overflow status", 32'h1, rd);
    chk("pin enable swi", 32'h1, 32'(compareOutPinOeN));
    apb(1'b1, `CAT_OFF_STAT, 32'h1);
    apb(1'b0, `CAT_OFF_STAT, 32'h0);
    chk("status cleared", 32'h0, rd);
    chk("irq cleared", 32'h0, 32'(irq));
    // flag-only match with the interrupt masked off
    lfsr = nxt(lfsr);
    n = 16'h0100 + (lfsr & 16'h00FF);
    apb(1'b1, `CAT_OFF_MASK, 32'h0);
    v = convCount;
    prog(`CAT_MODE_SWI, 16'(n - 2), 16'(n));
    repeat (16) @(posedge ref_clk);
    apb(1'b0, `CAT_OFF_STAT, 32'h0);
    chk("match status", 32'h2, rd);
    chk("irq masked", 32'h0, 32'(irq));
    chk("no conversion swi", v, convCount);
    // trigger mode: period, count at trigger, flags
    apb(1'b1, `CAT_OFF_MASK, 32'h2);
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      n = 3 + (lfsr & 16'h7);
      v = convCount;
      prog(`CAT_MODE_TRIG, 16'h0, 16'(n));
      wait_for(0, cyc);
      apb(1'b0, `CAT_OFF_TMRL, 32'h0);
      chk("count at trigger", n, rd);
      wait_for(0, cyc);
      wait_for(0, cyc);
      chk("trigger period", 4 * (n + 1), cyc);
      apb(1'b0, `CAT_OFF_STAT, 32'h0);
      chk("trigger status", 32'h2, rd);
      chk("irq on match", 32'h1, 32'(irq));
      chk("conversions", v + 3, convCount);
      chk("pin enable trig", 32'h1, 32'(compareOutPinOeN));
    end
    // match removed before the reset tick
    wait_for(0, cyc);
    apb(1'b1, `CAT_OFF_CMPL, 32'(n + 64));
    apb(1'b0, `CAT_OFF_TMRL, 32'h0);
    chk("reset skipped", n + 1, rd);
    // byte write landing on the reset tick
    prog(`CAT_MODE_TRIG, 16'h0, 16'(n));
    wait_for(0, cyc);
    lfsr = nxt(lfsr);
    v = 16'h40 | (lfsr & 16'h3F);
    @(posedge ref_clk);
    apb(1'b1, `CAT_OFF_TMRL, 32'(v));
    apb(1'b0, `CAT_OFF_TMRL, 32'h0);
    chk("write beats reset", v, rd);
    // converter disabled, then device asleep
    for (int k = 0; k < 2; k++) begin
      enReq <= (k == 1);
      sleepReq <= (k == 1);
      base = startCount;
      v = convCount;
      prog(`CAT_MODE_TRIG, 16'h0, 16'(n));
      repeat (8 * (n + 1)) @(posedge ref_clk);
      apb(1'b0, `CAT_OFF_STAT, 32'h0);
      chk("gated status", (k == 1) ? 32'h0 : 32'h2, rd);
      chk("gated starts", base, startCount);
      chk("gated conversions", v, convCount);
    end
    enReq <= 1'b1;
    sleepReq <= 1'b0;
    for (int m = 8; m < 12; m++) begin
      apb(1'b1, `CAT_OFF_CTRL, 32'(m));
      #1;
      chk("pin enable by mode", (m < 10) ? 32'h0 : 32'h1, 32'(compareOutPinOeN));
    end
    // set, clear, set again on match; a zero control write then drops the latch
    for (int m = 0; m < 3; m++) begin
      prog((m == 1) ? `CAT_MODE_CLR : `CAT_MODE_SET, 16'(16'h01FD + m * 256),
           16'(16'h0200 + m * 256));
      wait_for(1, cyc);
      chk("pin on match", (m == 1) ? 32'h0 : 32'h1, 32'(compareOutPin));
    end
    apb(1'b1, `CAT_OFF_CTRL, 32'h0);
    @(posedge ref_clk);
    #1;
    chk("pin forced low", 32'h0, 32'(compareOutPin));
    chk("pin released", 32'h1, 32'(compareOutPinOeN));
    finish_test();
  end
endmodule // compare_autoconv_trigger_tb
`default_nettype wire
